// *** hw/irq_params.svh ***
/*
  Addresses, field ranges and reset values of the local interrupt
  level, vector base and general pin control slice.
  Assumes a 32-bit AHB-Lite data path and whole-word accesses.
*/
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// Word addresses
// ----------------------------------------------------------------
`define A_LEVEL   32'hFFF40084
`define A_VECIO   32'hFFF40088
`define A_STATUS  32'hFFF40090
`define A_MASK    32'hFFF40094

// ----------------------------------------------------------------
// Field ranges
// ----------------------------------------------------------------
`define F_LVL1    2:0
`define F_LVL2    6:4
`define F_LVL3    10:8
`define F_LVL4    14:12
`define F_LEVEL   15:0
`define F_VBASE   31:24
`define F_VBR0    31:28
`define F_VBR1    27:24
`define B_MASTER_INTERRUPT_ENABLE    23
`define B_SYSTEM_FAIL_STATUS   22
`define B_POWER_FAIL_STATUS    21
`define B_ABRT    20
`define F_OEN     19:16
`define F_OUT     15:12
`define F_IN      11:8
`define F_EVT     2:0

// ----------------------------------------------------------------
// Masks, reset values, event bits
// ----------------------------------------------------------------
`define M_LEVEL   16'h7777
`define R_LEVEL   16'h0000
`define R_VBASE   8'h00
`define R_NIBBLE  4'h0
`define R_EVT     3'h0
`define E_ABRT    0
`define E_POWER_FAIL_STATUS    1
`define E_SYSTEM_FAIL_STATUS   2
`define HTRANS_NS 1
`define NO_SRC    3'h0

`endif

// *** hw/irq_pkg.sv ***
/*
  Types shared by the interrupt level and pin control slice.
  Assumes irq_params.svh supplies every address and field.
*/
`default_nettype none

package irq_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DATA = 2'b01
  } phase_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } ahb_cmd_t;

  typedef struct packed {
    logic       abort;
    logic       acfail;
    logic       sysfail;
    logic [3:0] pins;
  } line_sample_t;

  typedef logic [2:0] level_t;

endpackage

`default_nettype wire

// *** hw/level_select.sv ***
/*
  Picks the highest local level among pending bus requests.
  Assumes pending inputs already synchronous; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none

module level_select (
  // Requests and their programmed levels
  input  wire logic [3:0]      pending,
  input  wire logic [15:0]     levels,
  input  wire logic            enable,
  // Winner
  output irq_pkg::level_t      level,
  output logic [2:0]           source
);

  // ----------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------
  // Level zero means the request is parked; ties go to the higher request
  always_comb begin
    irq_pkg::level_t lv;
    lv     = 3'h0;
    level  = 3'h0;
    source = 3'h0;
    for (int i = 0; i < 4; i++) begin
      lv = levels[i*4 +: 3];
      if (enable && pending[i] && lv != 3'h0 && lv >= level) begin
        level  = lv;
        source = 3'(i + 1);
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/irq_level_vector_io_control.sv ***
/*
  Interrupt level, vector base, master enable and general pin control
  behind an AHB-Lite slave, with sticky line events and one irq line.
  Assumes one clock, synchronous inputs and single whole-word transfers.
*/
// Our own choice: the AHB-Lite slave port.
// Summary of operation
// - Bits 8-15 of the level word hold read/write levels for bus requests 3 and 4.
// - Bits 0-7 of the level word hold read/write levels for bus requests 1 and 2.
// - The top byte of the vector word holds two read/write four-bit base vectors, reset zero.
// - Bits 16-19 set each general pin to output when one, input when zero, reset zero.
// - Bit 20 reads one while the abort button is held down.
// - Bit 21 reads one while the power fail line is asserted.
// - Bit 22 reads one while the system fail line is asserted.
// - Bit 23 is the master enable; while zero every interrupt is masked; resets zero.
// - Bits 12-15 drive the pin output values, bits 8-11 read back the pin samples.
`timescale 1ns/1ns
`default_nettype none
`include "irq_params.svh"

module irq_level_vector_io_control (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Bus requests and status lines
  input  wire logic [3:0]  bus_req,
  input  wire logic        abort_pressed,
  input  wire logic        acfail_active,
  input  wire logic        sysfail_active,
  // Local interrupt
  output logic             irq,
  output logic      [2:0]  local_level,
  output logic      [7:0]  local_vector,
  // General pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------
  irq_pkg::phase_t       phase_r, phase_nxt;
  irq_pkg::ahb_cmd_t     cmd_r, cmd_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  ready_r, ready_nxt;
  logic                  take;
  logic                  wr_en;
  logic [31:0]           rd_val;

  // Configuration and state
  logic [15:0]           level_r, level_nxt;
  logic [7:0]            vbase_r, vbase_nxt;
  logic [3:0]            oen_r, oen_nxt;
  logic [3:0]            out_r, out_nxt;
  logic                  master_interrupt_enable_r, master_interrupt_enable_nxt;
  logic [2:0]            status_r, status_nxt;
  logic [2:0]            mask_r, mask_nxt;
  irq_pkg::line_sample_t smp_r, smp_nxt;
  irq_pkg::line_sample_t prev_r;
  logic [2:0]            evt;

  // Outputs
  logic                  irq_r, irq_nxt;
  irq_pkg::level_t       lvl_r, lvl_nxt;
  logic [7:0]            vec_r, vec_nxt;
  irq_pkg::level_t       win_level;
  logic [2:0]            win_src;

  // Size is ignored: only whole-word transfers are expected
  assign take  = hsel && hready && htrans[`HTRANS_NS];
  assign wr_en = (phase_r == irq_pkg::PH_DATA) && cmd_r.write;

  // One wait state lets a write settle before a following read
  always_comb begin
    phase_nxt = phase_r;
    cmd_nxt   = cmd_r;
    rdata_nxt = rdata_r;
    ready_nxt = ready_r;
    case (phase_r)
      irq_pkg::PH_IDLE: begin
        if (take) begin
          phase_nxt     = irq_pkg::PH_DATA;
          cmd_nxt.addr  = haddr;
          cmd_nxt.write = hwrite;
          ready_nxt     = 1'b0;
        end
      end
      irq_pkg::PH_DATA: begin
        phase_nxt = irq_pkg::PH_IDLE;
        ready_nxt = 1'b1;
        rdata_nxt = cmd_r.write ? 32'h0000_0000 : rd_val;
      end
      default: begin
        phase_nxt = irq_pkg::PH_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= irq_pkg::PH_IDLE;
      cmd_r   <= '0;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b1;
    end else begin
      phase_r <= phase_nxt;
      cmd_r   <= cmd_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped addresses read zero and answer OKAY
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(cmd_r.addr, `A_LEVEL)) begin
      rd_val[`F_LEVEL] = level_r;
    end else if (hit(cmd_r.addr, `A_VECIO)) begin
      rd_val[`F_VBASE] = vbase_r;
      rd_val[`B_MASTER_INTERRUPT_ENABLE]  = master_interrupt_enable_r;
      rd_val[`B_SYSTEM_FAIL_STATUS] = smp_r.sysfail;
      rd_val[`B_POWER_FAIL_STATUS]  = smp_r.acfail;
      rd_val[`B_ABRT]  = smp_r.abort;
      rd_val[`F_OEN]   = oen_r;
      rd_val[`F_OUT]   = out_r;
      rd_val[`F_IN]    = smp_r.pins;
    end else if (hit(cmd_r.addr, `A_STATUS)) begin
      rd_val[`F_EVT] = status_r;
    end else if (hit(cmd_r.addr, `A_MASK)) begin
      rd_val[`F_EVT] = mask_r;
    end
  end

  // ----------------------------------------------------------------
  // Line sampling and events
  // ----------------------------------------------------------------
  always_comb begin
    smp_nxt.abort   = abort_pressed;
    smp_nxt.acfail  = acfail_active;
    smp_nxt.sysfail = sysfail_active;
    smp_nxt.pins    = pin_in;
    evt[`E_ABRT]    = smp_r.abort && !prev_r.abort;
    evt[`E_POWER_FAIL_STATUS]    = smp_r.acfail && !prev_r.acfail;
    evt[`E_SYSTEM_FAIL_STATUS]   = smp_r.sysfail && !prev_r.sysfail;
  end

  // Pin samples have no defined reset value; zero is as good as any
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_r  <= '0;
      prev_r <= '0;
    end else begin
      smp_r  <= smp_nxt;
      prev_r <= smp_r;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    level_nxt  = level_r;
    vbase_nxt  = vbase_r;
    oen_nxt    = oen_r;
    out_nxt    = out_r;
    master_interrupt_enable_nxt   = master_interrupt_enable_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    if (wr_en && hit(cmd_r.addr, `A_LEVEL)) begin
      level_nxt = hwdata[`F_LEVEL] & `M_LEVEL;
    end
    if (wr_en && hit(cmd_r.addr, `A_VECIO)) begin
      vbase_nxt = hwdata[`F_VBASE];
      master_interrupt_enable_nxt  = hwdata[`B_MASTER_INTERRUPT_ENABLE];
      oen_nxt   = hwdata[`F_OEN];
      out_nxt   = hwdata[`F_OUT];
    end
    if (wr_en && hit(cmd_r.addr, `A_MASK)) begin
      mask_nxt = hwdata[`F_EVT];
    end
    if (wr_en && hit(cmd_r.addr, `A_STATUS)) begin
      status_nxt = status_r & ~hwdata[`F_EVT];
    end
    // A new event beats a clear in the same cycle
    status_nxt = status_nxt | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_r  <= `R_LEVEL;
      vbase_r  <= `R_VBASE;
      oen_r    <= `R_NIBBLE;
      out_r    <= `R_NIBBLE;
      master_interrupt_enable_r   <= 1'b0;
      mask_r   <= `R_EVT;
      status_r <= `R_EVT;
    end else begin
      level_r  <= level_nxt;
      vbase_r  <= vbase_nxt;
      oen_r    <= oen_nxt;
      out_r    <= out_nxt;
      master_interrupt_enable_r   <= master_interrupt_enable_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Level selection and outputs
  // ----------------------------------------------------------------
  level_select u_sel (
    .pending (bus_req),
    .levels  (level_r),
    .enable  (master_interrupt_enable_r),
    .level   (win_level),
    .source  (win_src)
  );

  // Vector low nibble names the winning request; zero when none
  always_comb begin
    lvl_nxt = win_level;
    vec_nxt = {vbase_r[7:4], 1'b0, win_src};
    irq_nxt = master_interrupt_enable_r && |(status_r & mask_r);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_r <= 3'h0;
      vec_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      vec_r <= vec_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign hrdata       = rdata_r;
  assign hreadyout    = ready_r;
  assign hresp        = 1'b0;
  assign irq          = irq_r;
  assign local_level  = lvl_r;
  assign local_vector = vec_r;
  assign pin_oe       = oen_r;
  assign pin_out      = out_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence wr_level;
    phase_r == irq_pkg::PH_DATA && cmd_r.write && cmd_r.addr == `A_LEVEL;
  endsequence

  sequence wr_vecio;
    phase_r == irq_pkg::PH_DATA && cmd_r.write && cmd_r.addr == `A_VECIO;
  endsequence

  sequence rd_vecio;
    phase_r == irq_pkg::PH_DATA && !cmd_r.write && cmd_r.addr == `A_VECIO;
  endsequence

  level_high_a: assert property (
    wr_level |=> level_r[15:8] == ($past(hwdata[15:8]) & 8'h77))
    else $error("upper level fields not written");

  level_low_a: assert property (
    wr_level |=> level_r[7:0] == ($past(hwdata[7:0]) & 8'h77))
    else $error("lower level fields not written");

  single_level_a: assert property (
    master_interrupt_enable_r && bus_req == 4'h1 |=> local_level == $past(level_r[2:0]))
    else $error("pending request not shown at its level");

  vbase_wr_a: assert property (
    wr_vecio |=> vbase_r == $past(hwdata[`F_VBASE]))
    else $error("base vectors not written");

  dir_wr_a: assert property (
    wr_vecio |=> pin_oe == $past(hwdata[`F_OEN]))
    else $error("pin direction not written");

  abort_rd_a: assert property (
    rd_vecio |=> hreadyout && hrdata[`B_ABRT] == $past(abort_pressed, 2))
    else $error("abort status misread");

  acfail_rd_a: assert property (
    rd_vecio |=> hreadyout && hrdata[`B_POWER_FAIL_STATUS] == $past(acfail_active, 2))
    else $error("power fail status misread");

  sysfail_rd_a: assert property (
    rd_vecio |=> hreadyout && hrdata[`B_SYSTEM_FAIL_STATUS] == $past(sysfail_active, 2))
    else $error("system fail status misread");

  master_interrupt_enable_mask_a: assert property (
    !master_interrupt_enable_r |=> !irq && local_level == 3'h0)
    else $error("interrupt passed while masked");

  pin_data_a: assert property (
    wr_vecio |=> pin_out == $past(hwdata[`F_OUT]))
    else $error("pin output values not written");

  pin_sample_a: assert property (
    rd_vecio |=> hrdata[`F_IN] == $past(pin_in, 2))
    else $error("pin samples misread");

endmodule

`default_nettype wire

// *** tb/line_source_model.sv ***
/*
  Far side model: bus request sources, status lines, pin drivers.
  Assumes the bench calls set_lines right after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module line_source_model (
  // Clock
  input  wire logic       hclk,
  // Pin drive from the block
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pin_out,
  // Lines toward the block
  output logic      [3:0] bus_req,
  output logic            abort_pressed,
  output logic            acfail_active,
  output logic            sysfail_active,
  output logic      [3:0] pin_in
);
  logic [3:0] ext_drive;

  initial begin
    bus_req = 4'h0;
    abort_pressed = 1'h0;
    acfail_active = 1'h0;
    sysfail_active = 1'h0;
    ext_drive = 4'h0;
  end

  // Block wins where it drives, far side elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);

  task automatic set_lines(input logic [3:0] req, input logic [2:0] st,
                           input logic [3:0] ext);
    @(posedge hclk);
    bus_req <= req;
    abort_pressed <= st[0];
    acfail_active <= st[1];
    sysfail_active <= st[2];
    ext_drive <= ext;
  endtask
endmodule

`default_nettype wire

// *** tb/test_irq_level_vector_io_control.sv ***
/*
  Self-checking bench for the level, vector and pin slice.
  Assumes the line model stands on the far side.
*/
`timescale 1ns/1ns
`default_nettype none
`include "irq_params.svh"

module test_irq_level_vector_io_control;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, irq;
  logic        abort_pressed, acfail_active, sysfail_active;
  logic [3:0]  bus_req, pin_in, pin_out, pin_oe;
  logic [2:0]  local_level;
  logic [7:0]  local_vector;
  logic [31:0] exp_q[$];
  logic        dph = 1'h0;
  logic        dph_rd = 1'h0;
  logic [15:0] lfsr = 16'h105C;
  logic [31:0] v;
  logic [31:0] vio;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #50 hclk = ~hclk;

  irq_level_vector_io_control irq_level_vector_io_control_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bus_req(bus_req), .abort_pressed(abort_pressed),
    .acfail_active(acfail_active), .sysfail_active(sysfail_active),
    .irq(irq), .local_level(local_level), .local_vector(local_vector),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  line_source_model line_source_model_inst (
    .hclk(hclk), .pin_oe(pin_oe), .pin_out(pin_out), .bus_req(bus_req),
    .abort_pressed(abort_pressed), .acfail_active(acfail_active),
    .sysfail_active(sysfail_active), .pin_in(pin_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r = {r[30:0], lfsr[0]};
    end
    return r;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read: d is the expected word, queued for the monitor
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr) exp_q.push_back(d);
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
  endtask

  // ------------------------------------------------------------
  // Monitor
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (dph && hreadyout) begin
      if (dph_rd) check(hrdata, exp_q.pop_front());
      dph <= 1'h0;
    end
    if (hsel && htrans[1] && hreadyout) begin
      dph <= 1'h1;
      dph_rd <= !hwrite;
    end
  end

  initial begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    conclude();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    check(pin_oe, 4'h0);
    check(pin_out, 4'h0);
    check(hresp, 1'h0);
    line_source_model_inst.set_lines(4'h0, 3'h0, 4'hA);
    repeat (2) @(posedge hclk);
    bus(1'h0, `A_LEVEL, 32'h0);
    bus(1'h0, `A_VECIO, 32'h00000A00);
    bus(1'h0, `A_MASK, 32'h0);
    $display("reset test done");
    repeat (6) begin
      v = rnd();
      bus(1'h1, `A_LEVEL, v);
      bus(1'h0, `A_LEVEL, v & {16'h0, `M_LEVEL});
    end
    bus(1'h1, `A_LEVEL, 32'h00007253);
    bus(1'h1, 32'hFFF4008C, 32'hFFFFFFFF);
    bus(1'h0, 32'hFFF4008C, 32'h0);
    $display("level test done");
    bus(1'h1, `A_VECIO, 32'h67F5CF00);
    vio = 32'h6785CE00;
    bus(1'h0, `A_VECIO, vio);
    check(pin_oe, 4'h5);
    check(pin_out, 4'hC);
    for (int i = 0; i < 3; i++) begin
      line_source_model_inst.set_lines(4'h0, 3'h1 << i, 4'hA);
      repeat (3) @(posedge hclk);
      bus(1'h0, `A_VECIO, vio | (32'h1 << (20 + i)));
    end
    line_source_model_inst.set_lines(4'h0, 3'h0, 4'hA);
    bus(1'h0, `A_STATUS, 32'h7);
    check(irq, 1'h0);
    $display("pin test done");
    bus(1'h1, `A_MASK, 32'h7);
    repeat (2) @(posedge hclk);
    check(irq, 1'h1);
    bus(1'h1, `A_VECIO, 32'h6705C000);
    line_source_model_inst.set_lines(4'h5, 3'h0, 4'hA);
    repeat (3) @(posedge hclk);
    check(irq, 1'h0);
    check(local_level, 3'h0);
    bus(1'h1, `A_VECIO, 32'h6785C000);
    repeat (3) @(posedge hclk);
    check(irq, 1'h1);
    check(local_level, 3'h3);
    check(local_vector, 8'h61);
    line_source_model_inst.set_lines(4'h1, 3'h0, 4'hA);
    repeat (3) @(posedge hclk);
    check(local_level, 3'h3);
    check(local_vector, 8'h61);
    line_source_model_inst.set_lines(4'hF, 3'h0, 4'hA);
    repeat (3) @(posedge hclk);
    check(local_level, 3'h7);
    check(local_vector, 8'h64);
    bus(1'h1, `A_STATUS, 32'h7);
    repeat (2) @(posedge hclk);
    check(irq, 1'h0);
    bus(1'h0, `A_STATUS, 32'h0);
    $display("interrupt test done");
    conclude();
  end
endmodule

`default_nettype wire
